/* File: inc/camtl_pkg.sv */
// Constants, field layouts and reset values of the camera trigger and
// pixel map block. Assumes a 12-bit byte register address and 32-bit data.
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package camtl_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIX_W  = 10;
  localparam int NREG   = 35;

  // Printed register offsets, one entry per stored register.
  localparam logic [11:0] REG_OFS [NREG] = '{
    12'h102, 12'h103, 12'h104, 12'h108, 12'h10A, 12'h10C, 12'h10E, 12'h10F,
    12'h110, 12'h114, 12'h118, 12'h119, 12'h11A, 12'h11E, 12'h130, 12'h132,
    12'h134, 12'h136, 12'h138, 12'h13C, 12'h140, 12'h144, 12'h148, 12'h149,
    12'h14A, 12'h14B, 12'h14C, 12'h150, 12'h154, 12'h158, 12'h15C, 12'h160,
    12'h164, 12'h168, 12'h16C};
  localparam logic [31:0] M8  = 32'h0000_00FF;
  localparam logic [31:0] M16 = 32'h0000_FFFF;
  localparam logic [31:0] M32 = 32'hFFFF_FFFF;
  localparam logic [31:0] REG_MASK [NREG] = '{
    M32, M8, M32, M16, M16, M16, M8, M8, M32, M32, M8, M8, M32, M32, M16, M16,
    M16, M16, M32, M32, M32, M32, M8, M8, M8, M8, M8, M32, M32, M32, M32, M32,
    M32, M32, M32};
  localparam logic [31:0] PIX_RATE_INIT = 32'h0262_5A00;
  localparam logic [31:0] REG_RST [NREG] = '{
    PIX_RATE_INIT, 32'h4, 32'h0, 32'hA, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0,
    32'h3E8, 32'h0, 32'h1, 32'h0, 32'h3E8, 32'h0, 32'h0, 32'h4FE, 32'h3FF,
    32'h0, 32'h0, 32'h0, 32'h015E_F3C0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam int IDX_PIXCLK = 0;
  localparam int IDX_SRC    = 1;
  localparam int IDX_DLY    = 2;
  localparam int IDX_RATE   = 3;
  localparam int IDX_SMODE  = 4;
  localparam int IDX_MAP    = 5;
  localparam int IDX_COLS   = 16;
  localparam int IDX_ROWS   = 17;
  localparam int IDX_INT0   = 18;
  localparam int IDX_INT3   = 21;

  // Exposure values per profile type 1..3, slope first to last.
  localparam logic [31:0] INIT_INT [3][4] = '{
    '{32'h0, 32'h0, 32'h0, 32'h015E_F3C0},
    '{32'h0, 32'h0, 32'h0131_2D00, 32'h002D_C6C0},
    '{32'h01C9_C380, 32'h000D_BBA0, 32'h0001_5F90, 32'h0000_1004}};

  // Additional control registers.
  localparam logic [11:0] OFS_SEQ    = 12'h180;
  localparam logic [11:0] OFS_LUTA   = 12'h184;
  localparam logic [11:0] OFS_LUTD   = 12'h188;
  localparam logic [11:0] OFS_SOFT   = 12'h904;
  localparam logic [11:0] OFS_INIT   = 12'h905;
  localparam logic [11:0] OFS_STATUS = 12'h908;
  localparam logic [15:0] SEQ_RST    = 16'h0001;

  // Trigger sources, capture modes and map functions.
  localparam logic [7:0] SRC_EXT  = 8'h01;
  localparam logic [7:0] SRC_CC1  = 8'h02;
  localparam logic [7:0] SRC_SOFT = 8'h03;
  localparam logic [7:0] SRC_FREE = 8'h04;
  localparam logic [15:0] MODE_SINGLE = 16'h0001;
  localparam logic [15:0] MODE_SEQ    = 16'h0000;
  localparam logic [7:0] MAP_INV  = 8'h01;
  localparam logic [7:0] MAP_SR   = 8'h02;
  localparam logic [7:0] MAP_ISR  = 8'h03;
  localparam logic [7:0] MAP_SL   = 8'h04;
  localparam logic [7:0] MAP_ISL  = 8'h05;
  localparam logic [7:0] MAP_USER = 8'h06;
  localparam logic [7:0] MAP_TEST = 8'h07;
  localparam logic [10:0] INV_BASE = 11'h400;

  // Delay rounding: nanoseconds per second and half of it.
  localparam logic [63:0] NS_PER_S = 64'h0000_0000_3B9A_CA00;
  localparam logic [63:0] NS_HALF  = 64'h0000_0000_1DCD_6500;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10
  } camtl_state_t;

  typedef struct packed {
    logic [31:0] pix_rate;
    logic [7:0]  src;
    logic [31:0] dly;
    logic [15:0] rate;
    logic [15:0] smode;
    logic [15:0] map;
    logic [15:0] cols;
    logic [15:0] rows;
    logic [15:0] seq;
  } camtl_cfg_t;

endpackage

/* File: logic/camtl_top.sv */
// Camera trigger generator and pixel map stage with its register file.
// Assumes registers written from SYS_CLK_I and sensor data on PIX_CLK_I.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

module camtl_top
  import camtl_pkg::*;
#(
  parameter int SQ_LOG = 6
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [DATA_W-1:0] REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [DATA_W-1:0] REG_RDATA_O,
  input  wire logic              PIX_CLK_I,
  input  wire logic              EXT_TRIG_I,
  input  wire logic              CC1_I,
  output logic                   SENSOR_TRIG_O,
  input  wire logic [PIX_W-1:0]  PIX_DATA_I,
  input  wire logic              PIX_VALID_I,
  input  wire logic              PIX_LINE_I,
  input  wire logic              PIX_FRAME_I,
  output logic      [PIX_W-1:0]  PIX_DATA_O,
  output logic                   PIX_VALID_O,
  output logic                   PIX_LINE_O,
  output logic                   PIX_FRAME_O
);

  //--------------------------------------------------------------------------
  // Register file on the system clock
  //--------------------------------------------------------------------------
  logic [31:0]    regs_r [NREG];
  logic [NREG-1:0] hit;
  logic [31:0]    init_val [NREG];
  logic [15:0]    seq_r;
  logic [11:0]    luta_r;
  logic [9:0]     lut_mem [0:3071];
  logic           soft_tgl_r;
  logic [31:0]    rd_regs;
  logic [31:0]    rd_val;
  logic           wr_any;
  logic           init_wr;
  logic [1:0]     init_sel;
  logic           lut_wr;
  logic [11:0]    lut_idx;

  // Address decode and profile initialisation selection.
  assign init_wr  = REG_WR_I && (REG_ADDR_I == OFS_INIT) &&
                    (REG_WDATA_I[3:0] >= 4'h1) && (REG_WDATA_I[3:0] <= 4'h3);
  assign init_sel = 2'(REG_WDATA_I[3:0] - 4'h1);
  assign wr_any   = (REG_WR_I && (|hit)) || init_wr;
  assign lut_wr   = REG_WR_I && (REG_ADDR_I == OFS_LUTD) &&
                    (luta_r[11:10] != 2'h3);
  assign lut_idx  = 12'({2'h0, luta_r[11:10]} * 4'h4 * 12'h100) +
                    {2'h0, luta_r[9:0]};

  // One stored register per printed offset, loaded by write or profile init.
  for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
    assign hit[gi] = (REG_ADDR_I == REG_OFS[gi]);
    if (gi >= IDX_INT0 && gi <= IDX_INT3) begin : g_int
      assign init_val[gi] = INIT_INT[init_sel][gi-IDX_INT0];
    end else begin : g_plain
      assign init_val[gi] = REG_RST[gi];
    end
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        regs_r[gi] <= REG_RST[gi];
      end else if (REG_WR_I && hit[gi]) begin
        regs_r[gi] <= REG_WDATA_I & REG_MASK[gi];
      end else if (init_wr) begin
        regs_r[gi] <= init_val[gi];
      end
    end
  end

  // Snapshot count, table pointer and software trigger toggle.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      seq_r      <= SEQ_RST;
      luta_r     <= 12'h000;
      soft_tgl_r <= 1'b0;
    end else begin
      if (REG_WR_I && REG_ADDR_I == OFS_SEQ) begin
        seq_r <= REG_WDATA_I[15:0];
      end
      if (REG_WR_I && REG_ADDR_I == OFS_LUTA) begin
        luta_r <= REG_WDATA_I[11:0];
      end else if (REG_WR_I && REG_ADDR_I == OFS_LUTD) begin
        luta_r <= {luta_r[11:10], 10'(luta_r[9:0] + 10'h001)};
      end
      if (REG_WR_I && REG_ADDR_I == OFS_SOFT && REG_WDATA_I[0]) begin
        soft_tgl_r <= ~soft_tgl_r;
      end
    end
  end

  // User table storage, written here and read on the pixel clock.
  always_ff @(posedge SYS_CLK_I) begin
    if (lut_wr) begin
      lut_mem[lut_idx] <= REG_WDATA_I[9:0];
    end
  end

  //--------------------------------------------------------------------------
  // Configuration hand-over to the pixel clock
  //--------------------------------------------------------------------------
  camtl_cfg_t cfg_live;
  camtl_cfg_t cfg_shadow_r;
  logic       dirty_r;
  logic       req_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       busy_s1_r;
  logic       busy_s2_r;
  logic       xfer_idle;
  logic       load;
  logic       ack_pix;
  logic       busy_pix;

  assign cfg_live = '{pix_rate: regs_r[IDX_PIXCLK], src: regs_r[IDX_SRC][7:0],
                      dly: regs_r[IDX_DLY], rate: regs_r[IDX_RATE][15:0],
                      smode: regs_r[IDX_SMODE][15:0],
                      map: regs_r[IDX_MAP][15:0],
                      cols: regs_r[IDX_COLS][15:0],
                      rows: regs_r[IDX_ROWS][15:0], seq: seq_r};
  assign xfer_idle = (req_r == ack_s2_r);
  assign load      = xfer_idle && dirty_r;

  // Shadow copy stays still until the pixel side has echoed the toggle.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg_shadow_r <= camtl_cfg_t'(0);
      dirty_r      <= 1'b1;
      req_r        <= 1'b0;
      ack_s1_r     <= 1'b0;
      ack_s2_r     <= 1'b0;
      busy_s1_r    <= 1'b0;
      busy_s2_r    <= 1'b0;
    end else begin
      ack_s1_r  <= ack_pix;
      ack_s2_r  <= ack_s1_r;
      busy_s1_r <= busy_pix;
      busy_s2_r <= busy_s1_r;
      dirty_r   <= wr_any || (REG_WR_I && REG_ADDR_I == OFS_SEQ) ||
                   (dirty_r && !load);
      if (load) begin
        cfg_shadow_r <= cfg_live;
        req_r        <= ~req_r;
      end
    end
  end

  // Read mux; unmapped and write-only addresses read as zero.
  always_comb begin
    rd_regs = 32'h0;
    for (int i = 0; i < NREG; i++) begin
      rd_regs = rd_regs | (hit[i] ? regs_r[i] : 32'h0);
    end
  end
  assign rd_val = (REG_ADDR_I == OFS_SEQ)    ? {16'h0, seq_r} :
                  (REG_ADDR_I == OFS_LUTA)   ? {20'h0, luta_r} :
                  (REG_ADDR_I == OFS_STATUS) ? {30'h0, !xfer_idle || dirty_r,
                                                busy_s2_r} :
                  rd_regs;

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 32'h0;
    end else begin
      REG_RDATA_O <= REG_RD_I ? rd_val : 32'h0;
    end
  end

  //--------------------------------------------------------------------------
  // Pixel clock domain: reset release, synchronisers, configuration
  //--------------------------------------------------------------------------
  logic       prst_s1_r;
  logic       prst_s2_r;
  logic [2:0] rq_r;
  logic [2:0] st_r;
  logic [2:0] ext_r;
  logic [2:0] cc1_r;
  camtl_cfg_t cfg_r;
  logic       cfg_new;
  logic       soft_ev;
  logic       ext_rise;
  logic       cc1_rise;

  localparam camtl_cfg_t CFG_RST = '{pix_rate: REG_RST[IDX_PIXCLK],
    src: REG_RST[IDX_SRC][7:0], dly: REG_RST[IDX_DLY],
    rate: REG_RST[IDX_RATE][15:0], smode: REG_RST[IDX_SMODE][15:0],
    map: REG_RST[IDX_MAP][15:0], cols: REG_RST[IDX_COLS][15:0],
    rows: REG_RST[IDX_ROWS][15:0], seq: SEQ_RST};

  // Reset is asserted at once and released on the pixel clock.
  always_ff @(posedge PIX_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prst_s1_r <= 1'b0;
      prst_s2_r <= 1'b0;
    end else begin
      prst_s1_r <= 1'b1;
      prst_s2_r <= prst_s1_r;
    end
  end

  assign cfg_new  = rq_r[1] ^ rq_r[2];
  assign ack_pix  = rq_r[2];
  assign soft_ev  = st_r[1] ^ st_r[2];
  assign ext_rise = ext_r[1] && !ext_r[2];
  assign cc1_rise = cc1_r[1] && !cc1_r[2];

  // Two stages before use, a third one for edge detection.
  always_ff @(posedge PIX_CLK_I or negedge prst_s2_r) begin
    if (!prst_s2_r) begin
      rq_r  <= 3'h0;
      st_r  <= 3'h0;
      ext_r <= 3'h0;
      cc1_r <= 3'h0;
      cfg_r <= CFG_RST;
    end else begin
      rq_r  <= {rq_r[1:0], req_r};
      st_r  <= {st_r[1:0], soft_tgl_r};
      ext_r <= {ext_r[1:0], EXT_TRIG_I};
      cc1_r <= {cc1_r[1:0], CC1_I};
      if (cfg_new) begin
        cfg_r <= cfg_shadow_r;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Trigger generator
  //--------------------------------------------------------------------------
  camtl_state_t state_r;
  camtl_state_t state_nxt;
  logic [63:0]  dly_acc_r;
  logic [32:0]  frm_acc_r;
  logic [31:0]  rdout_r;
  logic [15:0]  shots_r;
  logic         pend_r;
  logic         trig_hit;
  logic         tick;
  logic         fire;
  logic         last_shot;
  logic [32:0]  frm_sum;

  // Source selection; free-running source also covers the boot trigger.
  assign trig_hit = (cfg_r.src == SRC_EXT  && ext_rise) ||
                    (cfg_r.src == SRC_CC1  && cc1_rise) ||
                    (cfg_r.src == SRC_SOFT && soft_ev)  ||
                    (cfg_r.src == SRC_FREE);
  // Rate accumulator: one tick per pix_rate/rate pixel clocks.
  assign frm_sum   = frm_acc_r + {17'h0, cfg_r.rate};
  assign tick      = (state_r == ST_RUN) &&
                     (frm_acc_r >= {1'b0, cfg_r.pix_rate});
  assign fire      = (state_r == ST_RUN) && pend_r && (rdout_r == 32'h0);
  assign last_shot = fire &&
                     ((cfg_r.smode == MODE_SINGLE) ||
                      (cfg_r.smode == MODE_SEQ &&
                       16'(shots_r + 16'h1) >= cfg_r.seq));
  assign busy_pix  = (state_r != ST_IDLE);

  // Next state of the trigger sequencer.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:  if (trig_hit) state_nxt = ST_DELAY;
      ST_DELAY: if (dly_acc_r < NS_HALF) state_nxt = ST_RUN;
      ST_RUN:   if (last_shot) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
    if (cfg_new) begin
      state_nxt = ST_IDLE;
    end
  end

  // Delay counts down in nanosecond-hertz units, rounded to nearest period.
  always_ff @(posedge PIX_CLK_I or negedge prst_s2_r) begin
    if (!prst_s2_r) begin
      state_r   <= ST_IDLE;
      dly_acc_r <= 64'h0;
      frm_acc_r <= 33'h0;
      shots_r   <= 16'h0;
      pend_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        dly_acc_r <= {32'h0, cfg_r.dly} * {32'h0, cfg_r.pix_rate};
        frm_acc_r <= {1'b0, cfg_r.pix_rate};
        shots_r   <= 16'h0;
        pend_r    <= 1'b0;
      end else if (state_r == ST_DELAY) begin
        dly_acc_r <= (dly_acc_r < NS_PER_S) ? 64'h0 : dly_acc_r - NS_PER_S;
      end else begin
        frm_acc_r <= tick ? frm_sum - {1'b0, cfg_r.pix_rate} : frm_sum;
        pend_r    <= tick || (pend_r && !fire);
        if (fire) begin
          shots_r <= 16'(shots_r + 16'h1);
        end
      end
    end
  end

  // Readout of the region takes one pixel clock per pixel.
  always_ff @(posedge PIX_CLK_I or negedge prst_s2_r) begin
    if (!prst_s2_r) begin
      rdout_r       <= 32'h0;
      SENSOR_TRIG_O <= 1'b0;
    end else begin
      SENSOR_TRIG_O <= fire;
      if (fire) begin
        rdout_r <= {16'h0, cfg_r.cols} * {16'h0, cfg_r.rows};
      end else if (rdout_r != 32'h0) begin
        rdout_r <= rdout_r - 32'h1;
      end
    end
  end

  //--------------------------------------------------------------------------
  // Pixel map stage
  //--------------------------------------------------------------------------
  logic [PIX_W-1:0] x_r;
  logic [PIX_W-1:0] y_r;
  logic [PIX_W-1:0] cur_x;
  logic [PIX_W-1:0] cur_y;
  logic [PIX_W-1:0] inv_v;
  logic [PIX_W-1:0] map_v;
  logic [PIX_W-1:0] ramp_v;
  logic [SQ_LOG:0]  sq_sum;
  logic [3:0]       sh_n;
  logic [7:0]       fn;
  logic [11:0]      tab_idx;

  assign fn      = cfg_r.map[15:8];
  assign sh_n    = cfg_r.map[3:0];
  assign cur_x   = PIX_LINE_I ? '0 : x_r;
  assign cur_y   = PIX_FRAME_I ? '0 :
                   PIX_LINE_I ? PIX_W'(y_r + 1'b1) : y_r;
  assign inv_v   = PIX_W'(INV_BASE - {1'b0, PIX_DATA_I});
  assign sq_sum  = {1'b0, cur_x[SQ_LOG-1:0]} + {1'b0, cur_y[SQ_LOG-1:0]};
  assign ramp_v  = PIX_W'({sq_sum, {(PIX_W-SQ_LOG-1){1'b0}}});
  assign tab_idx = 12'({4'h0, cfg_r.map[7:0] - 8'h1} * 12'h400) +
                   {2'h0, PIX_DATA_I};

  // Function selection; unknown codes pass the data unchanged.
  assign map_v =
    (fn == MAP_INV)  ? inv_v :
    (fn == MAP_SR)   ? PIX_DATA_I >> sh_n :
    (fn == MAP_ISR)  ? inv_v >> sh_n :
    (fn == MAP_SL)   ? PIX_DATA_I << sh_n :
    (fn == MAP_ISL)  ? inv_v << sh_n :
    (fn == MAP_USER && cfg_r.map[7:0] >= 8'h1 && cfg_r.map[7:0] <= 8'h3) ?
      lut_mem[tab_idx] :
    (fn == MAP_TEST) ? ramp_v :
    PIX_DATA_I;

  // Position counters and registered output stream.
  always_ff @(posedge PIX_CLK_I or negedge prst_s2_r) begin
    if (!prst_s2_r) begin
      x_r         <= '0;
      y_r         <= '0;
      PIX_DATA_O  <= '0;
      PIX_VALID_O <= 1'b0;
      PIX_LINE_O  <= 1'b0;
      PIX_FRAME_O <= 1'b0;
    end else begin
      PIX_VALID_O <= PIX_VALID_I;
      PIX_LINE_O  <= PIX_VALID_I && PIX_LINE_I;
      PIX_FRAME_O <= PIX_VALID_I && PIX_FRAME_I;
      if (PIX_VALID_I) begin
        x_r        <= PIX_W'(cur_x + 1'b1);
        y_r        <= cur_y;
        PIX_DATA_O <= map_v;
      end
    end
  end

endmodule

/* File: verif/camtl_asserts.sv */
// Concurrent checks on the top-level ports of the trigger and map block.
// Assumes it is bound onto camtl_top and watches only its ports.
`timescale 1ns/1ps

module camtl_asserts
  import camtl_pkg::*;
#(
  parameter int SQ_LOG = 6
) (
  input wire logic              SYS_CLK_I,
  input wire logic              RESET_N_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic              REG_RD_I,
  input wire logic [DATA_W-1:0] REG_RDATA_O,
  input wire logic              PIX_CLK_I,
  input wire logic              SENSOR_TRIG_O,
  input wire logic              PIX_VALID_I,
  input wire logic              PIX_LINE_I,
  input wire logic              PIX_FRAME_I,
  input wire logic [PIX_W-1:0]  PIX_DATA_O,
  input wire logic              PIX_VALID_O,
  input wire logic              PIX_LINE_O,
  input wire logic              PIX_FRAME_O
);
  //--------------------------------------------------------------------------
  // Properties
  //--------------------------------------------------------------------------
  // A read of the trigger register is the first step of a refused access.
  sequence s_soft_rd;
    REG_RD_I && REG_ADDR_I == OFS_SOFT;
  endsequence
  property p_wo;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    s_soft_rd |=> REG_RDATA_O == '0;
  endproperty
  property p_rd;
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
    !REG_RD_I |=> REG_RDATA_O == '0;
  endproperty
  property p_vld;
    @(posedge PIX_CLK_I) disable iff (!RESET_N_I)
    PIX_VALID_I |=> PIX_VALID_O;
  endproperty
  property p_novld;
    @(posedge PIX_CLK_I) disable iff (!RESET_N_I)
    !PIX_VALID_I |=> !PIX_VALID_O && $stable(PIX_DATA_O);
  endproperty
  property p_line;
    @(posedge PIX_CLK_I) disable iff (!RESET_N_I)
    PIX_VALID_I && PIX_LINE_I |=> PIX_LINE_O;
  endproperty
  property p_frame;
    @(posedge PIX_CLK_I) disable iff (!RESET_N_I)
    PIX_VALID_I && PIX_FRAME_I |=> PIX_FRAME_O;
  endproperty
  property p_gap;
    @(posedge PIX_CLK_I) disable iff (!RESET_N_I)
    SENSOR_TRIG_O |=> !SENSOR_TRIG_O;
  endproperty
  property p_first;
    @(posedge PIX_CLK_I) disable iff (!RESET_N_I)
    $rose(PIX_FRAME_O) |-> PIX_VALID_O;
  endproperty

  a_wo: assert property (p_wo) else $error("trigger reg read not 0");
  a_rd: assert property (p_rd) else $error("idle read data not 0");
  a_vld: assert property (p_vld) else $error("valid lost");
  a_novld: assert property (p_novld) else $error("idle output moved");
  a_line: assert property (p_line) else $error("line flag lost");
  a_frame: assert property (p_frame) else $error("frame flag lost");
  a_gap: assert property (p_gap) else $error("trigger pulses too close");
  a_first: assert property (p_first) else $error("frame w/o valid");
endmodule

bind camtl_top camtl_asserts #(.SQ_LOG(SQ_LOG)) u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .PIX_CLK_I(PIX_CLK_I),
  .SENSOR_TRIG_O(SENSOR_TRIG_O), .PIX_VALID_I(PIX_VALID_I),
  .PIX_LINE_I(PIX_LINE_I), .PIX_FRAME_I(PIX_FRAME_I),
  .PIX_DATA_O(PIX_DATA_O), .PIX_VALID_O(PIX_VALID_O),
  .PIX_LINE_O(PIX_LINE_O), .PIX_FRAME_O(PIX_FRAME_O));

/* File: verif/camtl_grabber.sv */
// Frame grabber model: drives camera-control line one, counts frames.
// Assumes it runs on the pixel clock of the block under test.
`timescale 1ns/1ps

module camtl_grabber (
  input  wire logic pclk_i,
  input  wire logic valid_i,
  input  wire logic frame_i,
  output logic      cc1_o,
  output int        n_frames_o
);
  //--------------------------------------------------------------------------
  // Control line and frame count
  //--------------------------------------------------------------------------
  // Idle low from time zero so the synchroniser never sees an unknown.
  initial begin
    cc1_o = 1'b0;
    n_frames_o = 0;
  end

  // Each frame start leaving the block is counted once.
  always @(posedge pclk_i) begin
    if (valid_i && frame_i) n_frames_o++;
  end

  // A two-cycle high pulse survives the two-flop synchroniser.
  task send_cc1;
    @(posedge pclk_i);
    cc1_o <= 1'b1;
    repeat (2) @(posedge pclk_i);
    cc1_o <= 1'b0;
  endtask
endmodule

/* File: verif/camtl_top_tb.sv */
// Self-checking bench: register reads and writes, pixel maps, triggers.
// Assumes camtl_top, the bound checker and the grabber model.
`timescale 1ns/1ps

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module camtl_top_tb;
  import camtl_pkg::*;
  //--------------------------------------------------------------------------
  // Signals, clocks and instances
  //--------------------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        pix_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [11:0] addr    = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        ext     = 1'b0;
  logic [9:0]  pdi     = 10'h000;
  logic        pvi     = 1'b0;
  logic        pli     = 1'b0;
  logic        pfi     = 1'b0;
  logic [31:0] rdata, v;
  logic [9:0]  pdo;
  logic        strig, pvo, plo, pfo, cc1;
  int          failures = 0, n_compared = 0, pcyc = 0, npulse = 0;
  int          t_first, t_last, t_gap, t0, lat0, nfr;
  logic [15:0] mp [7] = '{16'h0100, 16'h0100, 16'h0203, 16'h0302,
                          16'h0403, 16'h0501, 16'h0000};
  logic [9:0]  pin [7] = '{10'h005, 10'h000, 10'h3FF, 10'h005,
                           10'h3FF, 10'h005, 10'h155};
  logic [9:0]  pex [7] = '{10'h3FB, 10'h000, 10'h07F, 10'h0FE,
                           10'h3F8, 10'h3F6, 10'h155};

  always #5 sys_clk = ~sys_clk;
  always #24 pix_clk = ~pix_clk;

  camtl_top #(.SQ_LOG(6)) u_dut (
    .SYS_CLK_I(sys_clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .PIX_CLK_I(pix_clk), .EXT_TRIG_I(ext), .CC1_I(cc1),
    .SENSOR_TRIG_O(strig), .PIX_DATA_I(pdi), .PIX_VALID_I(pvi),
    .PIX_LINE_I(pli), .PIX_FRAME_I(pfi), .PIX_DATA_O(pdo),
    .PIX_VALID_O(pvo), .PIX_LINE_O(plo), .PIX_FRAME_O(pfo));
  camtl_grabber u_fg (.pclk_i(pix_clk), .valid_i(pvo), .frame_i(pfo),
    .cc1_o(cc1), .n_frames_o(nfr));

  // Counts pixel cycles and records the timing of sensor trigger pulses.
  always @(posedge pix_clk) begin
    pcyc++;
    if (strig === 1'b1) begin
      if (npulse == 0) t_first = pcyc;
      else t_gap = pcyc - t_last;
      t_last = pcyc;
      npulse++;
    end
  end

  //--------------------------------------------------------------------------
  // Access tasks
  //--------------------------------------------------------------------------
  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a; rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task chk_rd(input logic [11:0] a, input logic [31:0] e);
    rd_reg(a, v);
    `CHK(v, e)
  endtask
  // Waits, bounded, until the pixel side has adopted the new settings.
  task settle;
    for (int i = 0; i < 60; i++) begin
      rd_reg(OFS_STATUS, v);
      if (v[1] === 1'b0) break;
    end
    `CHK(v[1], 1'b0)
  endtask
  task pix(input logic [9:0] d, input logic f, input logic l,
           input logic [9:0] e);
    @(posedge pix_clk);
    pdi <= d; pvi <= 1'b1; pfi <= f; pli <= l;
    @(posedge pix_clk);
    pvi <= 1'b0; pfi <= 1'b0; pli <= 1'b0;
    @(negedge pix_clk);
    `CHK(pdo, e)
  endtask
  task cfg(input logic [7:0] s, input logic [15:0] m, input logic [31:0] d);
    npulse = 0;
    wr_reg(12'h103, {24'h0, s});
    wr_reg(12'h10A, {16'h0, m});
    wr_reg(12'h104, d);
    settle();
  endtask
  // Raises a trigger of the given kind and watches 300 pixel cycles.
  task fire(input int k);
    @(posedge pix_clk);
    if (k == 1) ext <= 1'b1;
    #1 t0 = pcyc;
    if (k == 1) repeat (2) @(posedge pix_clk);
    ext <= 1'b0;
    if (k == 2) u_fg.send_cc1();
    if (k == 3) wr_reg(OFS_SOFT, 32'h1);
    repeat (300) @(posedge pix_clk);
  endtask
  task wrap_up;
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400_000;
    failures++;
    wrap_up();
  end

  //--------------------------------------------------------------------------
  // Test sequence
  //--------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_rd(12'h103, 32'h4);
    chk_rd(12'h134, 32'h4FE);
    chk_rd(12'h136, 32'h3FF);
    chk_rd(12'h144, 32'h015E_F3C0);
    chk_rd(12'h200, 32'h0);
    chk_rd(OFS_SOFT, 32'h0);
    wr_reg(12'h138, 32'h5);
    wr_reg(OFS_INIT, 32'h1);
    chk_rd(12'h138, 32'h0);
    wr_reg(OFS_INIT, 32'h3);
    chk_rd(12'h138, 32'h01C9_C380);
    wr_reg(12'h103, 32'hFFFF_FF03);
    chk_rd(12'h103, 32'h3);
    wr_reg(12'h102, 32'h000F_4240);
    chk_rd(12'h102, 32'h000F_4240);
    for (int i = 0; i < 7; i++) begin
      wr_reg(12'h10C, {16'h0, mp[i]});
      settle();
      pix(pin[i], 1'b0, 1'b0, pex[i]);
    end
    wr_reg(OFS_LUTA, 32'h007);
    wr_reg(OFS_LUTD, 32'h2AA);
    wr_reg(12'h10C, 32'h0601);
    settle();
    pix(10'h007, 1'b0, 1'b0, 10'h2AA);
    wr_reg(12'h10C, 32'h0700);
    settle();
    pix(10'h009, 1'b1, 1'b1, 10'h000);
    pix(10'h009, 1'b0, 1'b0, 10'h008);
    pix(10'h009, 1'b0, 1'b1, 10'h008);
    `CHK(nfr, 1)
    wr_reg(12'h108, 32'hC350);
    wr_reg(12'h134, 32'h2);
    wr_reg(12'h136, 32'h2);
    wr_reg(OFS_SEQ, 32'h3);
    cfg(SRC_EXT, MODE_SINGLE, 32'h0);
    fire(1);
    `CHK(npulse, 1)
    lat0 = t_first - t0;
    cfg(SRC_EXT, MODE_SINGLE, 32'd2600);
    fire(1);
    `CHK(t_first - t0, lat0 + 3)
    cfg(SRC_SOFT, MODE_SEQ, 32'h0);
    fire(3);
    `CHK(npulse, 3)
    `CHK(t_gap, 20)
    cfg(SRC_CC1, MODE_SINGLE, 32'h0);
    fire(2);
    `CHK(npulse, 1)
    cfg(SRC_FREE, MODE_SINGLE, 32'h0);
    fire(0);
    `CHK(npulse > 0, 1'b1)
    wr_reg(12'h134, 32'h5);
    wr_reg(12'h136, 32'h6);
    cfg(SRC_SOFT, 16'h0002, 32'h0);
    fire(3);
    `CHK(t_gap, 31)
    `CHK(npulse >= 8, 1'b1)
    wrap_up();
  end
endmodule
